/* rtl/dssf_params.svh */
`ifndef DSSF_PARAMS_SVH
`define DSSF_PARAMS_SVH
// ----------------------------------------------------------------
// Device register map
// ----------------------------------------------------------------
`define DSSF_OFS_LSR     8'h00
`define DSSF_OFS_HSR     8'h04
`define DSSF_OFS_LCLR    8'h08
`define DSSF_OFS_HCLR    8'h0C
`define DSSF_OFS_CFG     8'h10
`define DSSF_OFS_CNT     8'h14
`define DSSF_STRIDE      8'h10
`define DSSF_RST_WORD    32'h0000_0000
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DSSF_EN_BIT      0
`define DSSF_FLOW_BIT    1
`define DSSF_FE_POS      0
`define DSSF_DME_POS     2
`define DSSF_TE_POS      3
`define DSSF_HT_POS      4
`define DSSF_TC_POS      5
`define DSSF_GRP_BASE(s) ((s) == 0 ? 0 : (s) == 1 ? 6 : (s) == 2 ? 16 : 22)
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSSF_CLK_NS      20
`define DSSF_ITEM_NS     40
`define DSSF_ITEM_CYC    ((`DSSF_ITEM_NS + `DSSF_CLK_NS - 1) / `DSSF_CLK_NS)
// ----------------------------------------------------------------
// Host command registers
// ----------------------------------------------------------------
`define DSSF_H_CMD       8'h00
`define DSSF_H_ARG       8'h04
`define DSSF_H_STS       8'h08
`define DSSF_H_LSTS      8'h0C
`define DSSF_H_HSTS      8'h10
`define DSSF_OP_START    3'h1
`define DSSF_OP_SUSPEND  3'h2
`define DSSF_OP_RESUME   3'h3
`define DSSF_OP_CLEAR    3'h4
`define DSSF_OP_STATUS   3'h5
`endif

/* rtl/dssf_pkg.sv */
package dssf_pkg;
   // Stream sequencing
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_DRAIN} dssf_strm_e;
   // Host sequencing
   typedef enum logic [3:0] {
      H_IDLE, H_WR_CNT, H_WR_EN, H_WR_DIS, H_POLL, H_POLL_WAIT,
      H_RD_CNT, H_RD_CNT_WAIT, H_WR_CLR, H_RD_LO, H_RD_LO_WAIT,
      H_RD_HI, H_RD_HI_WAIT
   } dssf_host_e;
   typedef logic [7:0]  dssf_addr_t;
   typedef logic [31:0] dssf_word_t;
endpackage : dssf_pkg

/* rtl/dssf_link_if.sv */
`timescale 1ns/100ps
interface dssf_link_if;
   dssf_pkg::dssf_addr_t bus_addr;
   dssf_pkg::dssf_word_t bus_wdata;
   logic                 bus_wr;
   logic                 bus_rd;
   dssf_pkg::dssf_word_t bus_rdata;
   logic [7:0]           periph_req;
   logic [7:0]           periph_last;
   logic [7:0]           item_ack;

   modport device (
      input  bus_addr, bus_wdata, bus_wr, bus_rd, periph_req, periph_last,
      output bus_rdata, item_ack
   );
   modport host (
      output bus_addr, bus_wdata, bus_wr, bus_rd, periph_req, periph_last,
      input  bus_rdata, item_ack
   );
endinterface : dssf_link_if

/* rtl/dssf_stream_dev.sv */
`timescale 1ns/100ps
`include "dssf_params.svh"
module dssf_stream_dev (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Link to the software end
   dssf_link_if.device      link,
   // Error events from the data path, one per stream
   input  wire logic [7:0]  err_xfer,
   input  wire logic [7:0]  err_direct,
   input  wire logic [7:0]  err_fifo,
   // Stream activity
   output logic [7:0]       stream_active
);

   // ----------------------------------------------------------------
   // Per-stream logic
   // ----------------------------------------------------------------
   logic [31:0] contrib_w [8];
   logic [31:0] cfg_rd_w  [8];
   logic [31:0] cnt_rd_w  [8];
   logic        ack_w     [8];
   logic        act_w     [8];

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gs
         localparam logic [7:0] CFG_A =
            8'(`DSSF_OFS_CFG + g * `DSSF_STRIDE);
         localparam logic [7:0] CNT_A =
            8'(`DSSF_OFS_CNT + g * `DSSF_STRIDE);
         localparam logic [7:0] CLR_A =
            (g >= 4) ? `DSSF_OFS_HCLR : `DSSF_OFS_LCLR;
         localparam int         BASE = `DSSF_GRP_BASE(g % 4);

         dssf_pkg::dssf_strm_e st_reg;
         logic                 en_reg;
         logic                 flow_reg;
         logic                 last_reg;
         logic [15:0]          cnt_reg;
         logic [15:0]          half_reg;
         logic [1:0]           item_reg;
         logic [4:0]           flag_reg;
         logic [4:0]           set_w;
         logic [4:0]           clr_w;
         logic                 cfg_wr;
         logic                 cnt_wr;
         logic                 clr_wr;
         logic                 item_done;
         logic                 item_idle;
         logic                 is_last;
         logic                 finish;
         logic                 start_ok;
         logic                 stop_req;

         // Decode and sequencing terms
         assign cfg_wr    = link.bus_wr && (link.bus_addr == CFG_A);
         assign cnt_wr    = link.bus_wr && (link.bus_addr == CNT_A);
         assign clr_wr    = link.bus_wr && (link.bus_addr == CLR_A);
         assign item_done = (item_reg == 2'h1);
         assign item_idle = (item_reg == 2'h0);
         assign is_last   = flow_reg ? last_reg : (cnt_reg == 16'h0001);
         assign stop_req  = cfg_wr && !link.bus_wdata[`DSSF_EN_BIT]
                            && (st_reg == dssf_pkg::S_RUN);
         assign start_ok  = cfg_wr && link.bus_wdata[`DSSF_EN_BIT]
                            && (st_reg == dssf_pkg::S_IDLE)
                            && (link.bus_wdata[`DSSF_FLOW_BIT]
                                || (cnt_reg != 16'h0000));
         assign finish    = (st_reg != dssf_pkg::S_IDLE)
                            && ((item_done && is_last)
                                || (st_reg == dssf_pkg::S_DRAIN
                                    && (item_done || item_idle)));

         // Stream state: run, drain the ongoing item, stop
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               st_reg <= dssf_pkg::S_IDLE;
            end else if (finish) begin
               st_reg <= dssf_pkg::S_IDLE;
            end else if (start_ok) begin
               st_reg <= dssf_pkg::S_RUN;
            end else if (stop_req) begin
               st_reg <= dssf_pkg::S_DRAIN;
            end
         end

         // Enable bit reads one until the stop has taken effect
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               en_reg <= 1'b0;
            end else if (finish) begin
               en_reg <= 1'b0;
            end else if (start_ok) begin
               en_reg <= 1'b1;
            end
         end

         // Flow owner, changeable only while idle
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               flow_reg <= 1'b0;
            end else if (cfg_wr && st_reg == dssf_pkg::S_IDLE) begin
               flow_reg <= link.bus_wdata[`DSSF_FLOW_BIT];
            end
         end

         // Item count: loaded while idle, counts down under own flow
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_reg <= 16'h0000;
            end else if (cnt_wr && st_reg == dssf_pkg::S_IDLE) begin
               cnt_reg <= link.bus_wdata[15:0];
            end else if (item_done && !flow_reg) begin
               cnt_reg <= cnt_reg - 16'h0001;
            end
         end

         // Half mark taken from the count at enable
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               half_reg <= 16'h0000;
            end else if (start_ok) begin
               half_reg <= {1'b0, cnt_reg[15:1]};
            end
         end

         // Item timer and last-item mark from the peripheral
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               item_reg <= 2'h0;
               last_reg <= 1'b0;
            end else if (st_reg == dssf_pkg::S_RUN && item_idle
                         && link.periph_req[g]) begin
               item_reg <= 2'(`DSSF_ITEM_CYC);
               last_reg <= link.periph_last[g];
            end else if (!item_idle) begin
               item_reg <= item_reg - 2'h1;
            end
         end

         // Flag set and write-one clear; a set wins over a clear
         assign set_w[0] = err_fifo[g];
         assign set_w[1] = err_direct[g];
         assign set_w[2] = err_xfer[g];
         assign set_w[3] = item_done && !flow_reg && (half_reg != 16'h0000)
                           && (cnt_reg - 16'h0001 == half_reg);
         assign set_w[4] = finish;
         assign clr_w[0] = clr_wr && link.bus_wdata[BASE + `DSSF_FE_POS];
         assign clr_w[1] = clr_wr && link.bus_wdata[BASE + `DSSF_DME_POS];
         assign clr_w[2] = clr_wr && link.bus_wdata[BASE + `DSSF_TE_POS];
         assign clr_w[3] = clr_wr && link.bus_wdata[BASE + `DSSF_HT_POS];
         assign clr_w[4] = clr_wr && link.bus_wdata[BASE + `DSSF_TC_POS];

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               flag_reg <= 5'h00;
            end else begin
               flag_reg <= set_w | (flag_reg & ~clr_w);
            end
         end

         // Place this stream's flags in its status word
         always_comb begin
            contrib_w[g] = `DSSF_RST_WORD;
            contrib_w[g][BASE + `DSSF_FE_POS]  = flag_reg[0];
            contrib_w[g][BASE + `DSSF_DME_POS] = flag_reg[1];
            contrib_w[g][BASE + `DSSF_TE_POS]  = flag_reg[2];
            contrib_w[g][BASE + `DSSF_HT_POS]  = flag_reg[3];
            contrib_w[g][BASE + `DSSF_TC_POS]  = flag_reg[4];
         end

         // Read words and handshakes
         assign cfg_rd_w[g] = {30'h0, flow_reg, en_reg};
         assign cnt_rd_w[g] = {16'h0000, cnt_reg};
         assign ack_w[g]    = item_done;
         assign act_w[g]    = (st_reg != dssf_pkg::S_IDLE);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Status words and read port
   // ----------------------------------------------------------------
   logic [31:0] lsr_w;
   logic [31:0] hsr_w;
   logic [31:0] rdata_next;
   logic [31:0] rdata_reg;

   // Gather streams 0-3 low, 4-7 high
   always_comb begin
      lsr_w = `DSSF_RST_WORD;
      hsr_w = `DSSF_RST_WORD;
      for (int n = 0; n < 4; n++) begin
         lsr_w = lsr_w | contrib_w[n];
         hsr_w = hsr_w | contrib_w[n + 4];
      end
   end

   // Read decode; clear registers and unmapped addresses read zero
   always_comb begin
      rdata_next = `DSSF_RST_WORD;
      if (link.bus_addr == `DSSF_OFS_LSR) begin
         rdata_next = lsr_w;
      end else if (link.bus_addr == `DSSF_OFS_HSR) begin
         rdata_next = hsr_w;
      end
      for (int n = 0; n < 8; n++) begin
         if (link.bus_addr == 8'(`DSSF_OFS_CFG + n * `DSSF_STRIDE)) begin
            rdata_next = cfg_rd_w[n];
         end
         if (link.bus_addr == 8'(`DSSF_OFS_CNT + n * `DSSF_STRIDE)) begin
            rdata_next = cnt_rd_w[n];
         end
      end
   end

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= `DSSF_RST_WORD;
      end else if (link.bus_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= `DSSF_RST_WORD;
      end
   end

   // Pack handshakes and activity
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         link.item_ack[n] = ack_w[n];
         stream_active[n] = act_w[n];
      end
   end

   assign link.bus_rdata = rdata_reg;

endmodule : dssf_stream_dev

/* rtl/dssf_sw_host.sv */
`timescale 1ns/100ps
`include "dssf_params.svh"
module dssf_sw_host (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Link to the stream device
   dssf_link_if.host        link,
   // Command register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   // Peripheral request side
   input  wire logic [7:0]  periph_req_in,
   input  wire logic [7:0]  periph_last_in,
   output logic [7:0]       item_ack_out
);

   // ----------------------------------------------------------------
   // Command registers
   // ----------------------------------------------------------------
   dssf_pkg::dssf_host_e st_reg;
   logic [2:0]           strm_reg;
   logic                 flow_reg;
   logic [31:0]          arg_reg;
   logic [15:0]          saved_reg;
   logic [31:0]          lsts_reg;
   logic [31:0]          hsts_reg;
   logic [31:0]          rdata_reg;
   logic [2:0]           op_w;
   logic                 cmd_go;
   logic [7:0]           cfg_a;
   logic [7:0]           cnt_a;

   assign op_w   = reg_wdata[6:4];
   assign cmd_go = reg_wr && (reg_addr == `DSSF_H_CMD)
                   && (st_reg == dssf_pkg::H_IDLE);
   assign cfg_a  = 8'(`DSSF_OFS_CFG + {5'h00, strm_reg} * `DSSF_STRIDE);
   assign cnt_a  = 8'(`DSSF_OFS_CNT + {5'h00, strm_reg} * `DSSF_STRIDE);

   // Latch command fields when idle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         strm_reg <= 3'h0;
         flow_reg <= 1'b0;
      end else if (cmd_go) begin
         strm_reg <= reg_wdata[2:0];
         flow_reg <= reg_wdata[8];
      end
   end

   // Argument register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arg_reg <= 32'h0000_0000;
      end else if (reg_wr && reg_addr == `DSSF_H_ARG) begin
         arg_reg <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Software sequence
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= dssf_pkg::H_IDLE;
      end else begin
         unique case (st_reg)
            dssf_pkg::H_IDLE: begin
               if (cmd_go) begin
                  unique case (op_w)
                     `DSSF_OP_START:   st_reg <= dssf_pkg::H_WR_CNT;
                     `DSSF_OP_SUSPEND: st_reg <= dssf_pkg::H_WR_DIS;
                     `DSSF_OP_RESUME:  st_reg <= dssf_pkg::H_WR_CNT;
                     `DSSF_OP_CLEAR:   st_reg <= dssf_pkg::H_WR_CLR;
                     `DSSF_OP_STATUS:  st_reg <= dssf_pkg::H_RD_LO;
                     default:          st_reg <= dssf_pkg::H_IDLE;
                  endcase
               end
            end
            dssf_pkg::H_WR_CNT:      st_reg <= dssf_pkg::H_WR_EN;
            dssf_pkg::H_WR_EN:       st_reg <= dssf_pkg::H_IDLE;
            dssf_pkg::H_WR_DIS:      st_reg <= dssf_pkg::H_POLL;
            dssf_pkg::H_POLL:        st_reg <= dssf_pkg::H_POLL_WAIT;
            dssf_pkg::H_POLL_WAIT: begin
               if (link.bus_rdata[`DSSF_EN_BIT]) begin
                  st_reg <= dssf_pkg::H_POLL;
               end else begin
                  st_reg <= dssf_pkg::H_RD_CNT;
               end
            end
            dssf_pkg::H_RD_CNT:      st_reg <= dssf_pkg::H_RD_CNT_WAIT;
            dssf_pkg::H_RD_CNT_WAIT: st_reg <= dssf_pkg::H_IDLE;
            dssf_pkg::H_WR_CLR:      st_reg <= dssf_pkg::H_IDLE;
            dssf_pkg::H_RD_LO:       st_reg <= dssf_pkg::H_RD_LO_WAIT;
            dssf_pkg::H_RD_LO_WAIT:  st_reg <= dssf_pkg::H_RD_HI;
            dssf_pkg::H_RD_HI:       st_reg <= dssf_pkg::H_RD_HI_WAIT;
            dssf_pkg::H_RD_HI_WAIT:  st_reg <= dssf_pkg::H_IDLE;
            default:                 st_reg <= dssf_pkg::H_IDLE;
         endcase
      end
   end

   // Count to load: argument on start, saved count on resume
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         saved_reg <= 16'h0000;
      end else if (cmd_go && op_w == `DSSF_OP_START) begin
         saved_reg <= arg_reg[15:0];
      end else if (st_reg == dssf_pkg::H_RD_CNT_WAIT) begin
         saved_reg <= link.bus_rdata[15:0];
      end
   end

   // Captured status words
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         lsts_reg <= 32'h0000_0000;
         hsts_reg <= 32'h0000_0000;
      end else if (st_reg == dssf_pkg::H_RD_LO_WAIT) begin
         lsts_reg <= link.bus_rdata;
      end else if (st_reg == dssf_pkg::H_RD_HI_WAIT) begin
         hsts_reg <= link.bus_rdata;
      end
   end

   // Bus master signals from the sequence state
   always_comb begin
      link.bus_addr  = 8'h00;
      link.bus_wdata = 32'h0000_0000;
      link.bus_wr    = 1'b0;
      link.bus_rd    = 1'b0;
      unique case (st_reg)
         dssf_pkg::H_WR_CNT: begin
            link.bus_addr  = cnt_a;
            link.bus_wdata = {16'h0000, saved_reg};
            link.bus_wr    = 1'b1;
         end
         dssf_pkg::H_WR_EN: begin
            link.bus_addr  = cfg_a;
            link.bus_wdata = {30'h0, flow_reg, 1'b1};
            link.bus_wr    = 1'b1;
         end
         dssf_pkg::H_WR_DIS: begin
            link.bus_addr  = cfg_a;
            link.bus_wdata = {30'h0, flow_reg, 1'b0};
            link.bus_wr    = 1'b1;
         end
         dssf_pkg::H_POLL: begin
            link.bus_addr = cfg_a;
            link.bus_rd   = 1'b1;
         end
         dssf_pkg::H_RD_CNT: begin
            link.bus_addr = cnt_a;
            link.bus_rd   = 1'b1;
         end
         dssf_pkg::H_WR_CLR: begin
            link.bus_addr  = strm_reg[2] ? `DSSF_OFS_HCLR : `DSSF_OFS_LCLR;
            link.bus_wdata = arg_reg;
            link.bus_wr    = 1'b1;
         end
         dssf_pkg::H_RD_LO: begin
            link.bus_addr = `DSSF_OFS_LSR;
            link.bus_rd   = 1'b1;
         end
         dssf_pkg::H_RD_HI: begin
            link.bus_addr = `DSSF_OFS_HSR;
            link.bus_rd   = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // Command port read data, one cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_rd && reg_addr == `DSSF_H_STS) begin
         rdata_reg <= {saved_reg, 15'h0000, st_reg != dssf_pkg::H_IDLE};
      end else if (reg_rd && reg_addr == `DSSF_H_LSTS) begin
         rdata_reg <= lsts_reg;
      end else if (reg_rd && reg_addr == `DSSF_H_HSTS) begin
         rdata_reg <= hsts_reg;
      end else if (reg_rd && reg_addr == `DSSF_H_ARG) begin
         rdata_reg <= arg_reg;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   // Peripheral requests and last marks pass to the link
   assign link.periph_req  = periph_req_in;
   assign link.periph_last = periph_last_in;
   assign item_ack_out     = link.item_ack;
   assign reg_rdata        = rdata_reg;

endmodule : dssf_sw_host

/* testbench/dssf_link_properties.sv */
`timescale 1ns/100ps
module dssf_link_properties (
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 arst_n,
   // Register bus
   input wire dssf_pkg::dssf_addr_t bus_addr,
   input wire dssf_pkg::dssf_word_t bus_wdata,
   input wire logic                 bus_wr,
   input wire logic                 bus_rd,
   input wire dssf_pkg::dssf_word_t bus_rdata,
   // Item handshake
   input wire logic [7:0]           periph_req,
   input wire logic [7:0]           periph_last,
   input wire logic [7:0]           item_ack
);
   // ----------------------------------------------------------------
   // Link checks
   // ----------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   logic cfg_a;
   // Stream configuration address decode
   assign cfg_a = bus_addr >= 8'h10 && bus_addr[3:0] == 4'h0;
   sequence s_poll;
      bus_rd && bus_addr == $past(bus_addr);
   endsequence
   sequence s_cfg_rd;
      bus_rd && cfg_a;
   endsequence
   property p_suspend_poll;
      bus_wr && cfg_a && !bus_wdata[0] |=> s_poll;
   endproperty
   property p_count_first;
      bus_wr && cfg_a && bus_wdata[0] && !bus_wdata[1] |->
         $past(bus_wr) && $past(bus_addr) == bus_addr + 8'h04;
   endproperty
   property p_count_read;
      s_cfg_rd ##1 !bus_rdata[0] |-> ##[1:2] bus_rd && bus_addr[3:0] == 4'h4;
   endproperty
   property p_poll_again;
      s_cfg_rd ##1 bus_rdata[0] |-> ##[1:2] s_cfg_rd;
   endproperty
   property p_clr_zero;
      !bus_rd || bus_addr[7:3] == 5'h01 |=> bus_rdata == 32'h0;
   endproperty
   property p_reserved;
      bus_rd && bus_addr[7:3] == 5'h00 |=> (bus_rdata & 32'hF082_F082) == 0;
   endproperty
   property p_ack_req;
      item_ack != 8'h00 |-> (item_ack & $past(periph_req, 2)) == item_ack;
   endproperty
   property p_ack_pulse;
      item_ack != 8'h00 |=> (item_ack & $past(item_ack)) == 8'h00;
   endproperty
   property p_one_strobe;
      !(bus_wr && bus_rd);
   endproperty
   a_suspend_poll: assert property (p_suspend_poll)
      else $error("no poll after disable");
   a_count_first: assert property (p_count_first)
      else $error("enable without count load");
   a_count_read: assert property (p_count_read)
      else $error("count not read after stop");
   a_poll_again: assert property (p_poll_again)
      else $error("poll not repeated");
   a_clr_zero: assert property (p_clr_zero)
      else $error("read data nonzero outside a status read");
   a_reserved: assert property (p_reserved)
      else $error("reserved status bit set");
   a_ack_req: assert property (p_ack_req)
      else $error("item done without request");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("item done longer than a cycle");
   a_one_strobe: assert property (p_one_strobe)
      else $error("write and read together");
endmodule : dssf_link_properties

/* testbench/dssf_stream_suspend_flow_status_tb.sv */
`timescale 1ns/100ps
module dssf_stream_suspend_flow_status_tb;
   // ----------------------------------------------------------------
   // Bench signals
   // ----------------------------------------------------------------
   logic        core_clk  = 1'b0;
   logic        arst_n    = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [7:0]  req = 8'h00, last = 8'h00, ex = 8'h00;
   logic [31:0] reg_rdata, rd, lo, hi;
   logic [7:0]  ack, active;
   int          num_errors = 0, comparisons = 0, left, acks[8];
   dssf_link_if dssf_link_if_i ();
   dssf_stream_dev dssf_stream_dev_i (.core_clk(core_clk), .arst_n(arst_n),
      .link(dssf_link_if_i.device), .err_xfer(ex), .err_direct(ex & 8'hF0),
      .err_fifo(ex & 8'h0F), .stream_active(active));
   dssf_sw_host dssf_sw_host_i (.core_clk(core_clk), .arst_n(arst_n),
      .link(dssf_link_if_i.host), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .periph_req_in(req), .periph_last_in(last), .item_ack_out(ack));
   dssf_link_properties dssf_link_properties_i (.core_clk(core_clk),
      .arst_n(arst_n), .bus_addr(dssf_link_if_i.bus_addr),
      .bus_wdata(dssf_link_if_i.bus_wdata), .bus_wr(dssf_link_if_i.bus_wr),
      .bus_rd(dssf_link_if_i.bus_rd), .bus_rdata(dssf_link_if_i.bus_rdata),
      .periph_req(dssf_link_if_i.periph_req),
      .periph_last(dssf_link_if_i.periph_last),
      .item_ack(dssf_link_if_i.item_ack));
   // Clock and finished item counts
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      for (int s = 0; s < 8; s++) acks[s] <= acks[s] + ack[s];
   end
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task check(input string what, input logic [31:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd_reg
   task cmd(input int op, s, fl, input logic [31:0] arg);
      int n;
      n = 0;
      wr(8'h04, arg);
      wr(8'h00, {23'h0, fl[0], 1'b0, op[2:0], 1'b0, s[2:0]});
      rd = 32'h1;
      while (rd[0] !== 1'b0 && n < 300) begin
         rd_reg(8'h08, rd);
         n++;
      end
      // A command that never goes idle counts as a mismatch
      if (rd[0] !== 1'b0) num_errors++;
   endtask : cmd
   task status;
      cmd(5, 0, 0, 32'h0);
      rd_reg(8'h0C, lo);
      rd_reg(8'h10, hi);
   endtask : status
   task wait_idle(input int s);
      for (int n = 0; n < 300 && active[s] !== 1'b0; n++) @(posedge core_clk);
      // A stream that never stops counts as a mismatch
      if (active[s] !== 1'b0) num_errors++;
   endtask : wait_idle
   task conclude;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      req <= 8'h20;
      cmd(1, 5, 0, 32'h4);
      wait_idle(5);
      check("items s5", 32'h4, acks[5]);
      status;
      check("high done", 32'h0000_0C00, hi);
      cmd(4, 5, 0, 32'h0000_0C00);
      status;
      check("high cleared", 32'h0, hi);
      req <= 8'h40;
      cmd(1, 6, 0, 32'hA);
      repeat (4) @(posedge core_clk);
      cmd(2, 6, 0, 32'h0);
      check("stopped s6", 32'h0, {31'h0, active[6]});
      left = 10 - acks[6];
      rd_reg(8'h08, rd);
      check("saved count", left, {16'h0, rd[31:16]});
      status;
      check("stop flags", left <= 5 ? 32'h30_0000 : 32'h20_0000, hi);
      cmd(4, 6, 0, 32'h0030_0000);
      cmd(3, 6, 0, 32'h0);
      wait_idle(6);
      check("items s6", 32'hA, acks[6]);
      status;
      check("resume", left / 2 != 0 ? 32'h30_0000 : 32'h20_0000, hi);
      cmd(4, 6, 0, 32'h0030_0000);
      req <= 8'h10;
      cmd(1, 4, 1, 32'h2);
      repeat (20) @(posedge core_clk);
      check("count ignored", 32'h1, {31'h0, acks[4] > 2});
      last <= 8'h10;
      wait_idle(4);
      req <= 8'h00;
      last <= 8'h00;
      status;
      check("last item", 32'h0000_0020, hi);
      cmd(4, 4, 0, 32'hFFFF_FFFF);
      @(posedge core_clk);
      ex <= 8'hFF;
      @(posedge core_clk);
      ex <= 8'h00;
      status;
      check("low errors", 32'h0249_0249, lo);
      check("high errors", 32'h030C_030C, hi);
      cmd(4, 0, 0, 32'hFFFF_FFFF);
      cmd(4, 4, 0, 32'hFFFF_FFFF);
      status;
      check("low clear", 32'h0, lo);
      check("high clear", 32'h0, hi);
      conclude();
   end
   // Watchdog
   initial begin
      #400000;
      num_errors++;
      conclude();
   end
endmodule : dssf_stream_suspend_flow_status_tb
